// File: core/irq_pin_front.sv
/*
 * external interrupt pin front end: pin select, synchroniser, digital filter,
 * trigger detect, sticky status, mask, routing and wake request.
 * assumes pins asynchronous to clock and a plain one-cycle register port.
 */
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module irq_pin_front
    import irq_pin_pkg::*;
#(
    parameter int pins = 8,
    parameter int lines = 4
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // pins and peripheral path
    input wire logic [pins-1:0] pin_in,
    output logic [pins-1:0] periph_in,
    // event outputs
    output logic [lines-1:0] evt_cpu,
    output logic [lines-1:0] evt_dtc,
    output logic [lines-1:0] evt_dma,
    output logic wake_req,
    output logic irq
);

    // the line number field of a pin is at most three bits wide
    if (pins < 1 || pins > 16 || lines < 1 || lines > 8)
    begin : bad_size
        $error("irq_pin_front: unsupported pins or lines");
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    localparam int lw = (lines > 1) ? $clog2(lines) : 1;
    logic [2:0] pin_function_reg [pins];
    logic [lw-1:0] pnum [pins];
    logic [7:0] ctl [lines];
    logic [lines-1:0] status, mask;
    logic [2*lines-1:0] route;
    logic [pins-1:0] s1, s2, s3, psync;
    logic [5:0] div_cnt;
    logic [lines-1:0] raw, filt, prev;
    logic [1:0] fhist [lines];
    logic [lines-1:0] evt;
    logic [lines-1:0] wake_line;
    logic [lines-1:0] used;

    // decode shared by the read mux and the write path
    function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int i);
        return a == base + 8'(4 * i);
    endfunction

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            psync <= '0;
        end
        else
        begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            psync <= (s2 == s3) ? s3 : psync;
        end
    end

    // ----------------------------------------------------------------
    // pin to line merge
    // ----------------------------------------------------------------
    // the two pins of one number are anded, so a line with no pin selected
    // stays at the idle high level and never looks like a low-level trigger;
    // if both pins are enabled the result is meaningless
    always_comb
    begin
        raw = '1;
        used = '0;
        wake_line = '0;
        for (int p = 0; p < pins; p++)
        begin
            if (pin_function_reg[p][pfs_irq_input_select_bit])
            begin
                raw[pnum[p]] = raw[pnum[p]] & psync[p];
                used[pnum[p]] = 1'b1;
                if (pin_function_reg[p][pfs_ds_bit])
                    wake_line[pnum[p]] = 1'b1;
            end
        end
    end

    // peripheral path ignores irq_input_select entirely
    logic [pins-1:0] psel_vec;
    always_comb
    begin
        for (int p = 0; p < pins; p++)
            psel_vec[p] = pin_function_reg[p][pfs_psel_bit];
    end

    // ----------------------------------------------------------------
    // sample rate divider
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 6'h01;
    end

    // ----------------------------------------------------------------
    // per line filter and trigger detect
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < lines; g++)
        begin : line
            wire [1:0] fsel = ctl[g][ctl_fclk_lsb +: 2];
            wire filter_enable_bit = ctl[g][ctl_filter_enable_bit_bit];
            wire tick = (fsel == 2'h0) ? 1'b1 :
                        (fsel == 2'h1) ? ((div_cnt & div8_last) == div8_last) :
                        (fsel == 2'h2) ? ((div_cnt & div32_last) == div32_last) :
                        (div_cnt == div64_last);
            wire agree = (fhist[g][0] == raw[g]) && (fhist[g][1] == raw[g]);
            wire next_filt = filter_enable_bit ? ((tick && agree) ? raw[g] : filt[g]) : raw[g];
            wire [1:0] mode = ctl[g][ctl_mode_lsb +: 2];
            wire det = (mode == trig_low) ? ~filt[g] :
                       (mode == trig_fall) ? (prev[g] & ~filt[g]) :
                       (mode == trig_rise) ? (~prev[g] & filt[g]) :
                       (prev[g] ^ filt[g]);

            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                begin
                    fhist[g] <= 2'h0;
                    filt[g] <= 1'b1;
                    prev[g] <= 1'b1;
                    evt[g] <= 1'b0;
                end
                else
                begin
                    if (tick)
                        fhist[g] <= {fhist[g][0], raw[g]};
                    filt[g] <= next_filt;
                    prev[g] <= filt[g];
                    evt[g] <= det;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // register writes, status and routing
    // ----------------------------------------------------------------
    wire st_wr = wr && (addr == irq_status_addr);
    wire [lines-1:0] st_clr = st_wr ? wdata[lines-1:0] : '0;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int p = 0; p < pins; p++)
            begin
                pin_function_reg[p] <= pfs_reset;
                pnum[p] <= '0;
            end
            for (int l = 0; l < lines; l++)
                ctl[l] <= ctl_reset;
            status <= '0;
            mask <= '0;
            route <= '0;
        end
        else
        begin
            for (int p = 0; p < pins; p++)
                if (wr && hit(addr, pin_function_reg_base, p))
                begin
                    pin_function_reg[p] <= wdata[2:0];
                    pnum[p] <= wdata[8 +: lw];
                end
            for (int l = 0; l < lines; l++)
                if (wr && hit(addr, irq_line_control_reg_base, l))
                    ctl[l] <= wdata[7:0];
            if (wr && addr == irq_mask_addr)
                mask <= wdata[lines-1:0];
            if (wr && addr == irq_route_addr)
                route <= wdata[2*lines-1:0];
            // a new event wins over a clear in the same cycle
            status <= (status & ~st_clr) | evt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = '0;
        for (int p = 0; p < pins; p++)
            if (hit(addr, pin_function_reg_base, p))
                next_rdata = {19'h0, 5'(pnum[p]), 5'h0, pin_function_reg[p]};
        for (int l = 0; l < lines; l++)
            if (hit(addr, irq_line_control_reg_base, l))
                next_rdata = {24'h0, ctl[l]};
        if (addr == irq_status_addr)
            next_rdata = 32'(status);
        if (addr == irq_mask_addr)
            next_rdata = 32'(mask);
        if (addr == irq_route_addr)
            next_rdata = 32'(route);
        if (addr == irq_wake_addr)
            next_rdata = 32'(wake_line);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdata <= '0;
            periph_in <= '0;
            evt_cpu <= '0;
            evt_dtc <= '0;
            evt_dma <= '0;
            wake_req <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            rdata <= rd ? next_rdata : '0;
            periph_in <= psync & psel_vec;
            for (int l = 0; l < lines; l++)
            begin
                evt_cpu[l] <= evt[l] && route[2*l +: 2] == 2'h0;
                evt_dtc[l] <= evt[l] && route[2*l +: 2] == 2'h1;
                evt_dma[l] <= evt[l] && route[2*l +: 2] == 2'h2;
            end
            wake_req <= |(wake_line & ~filt);
            irq <= |(status & mask);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_status_sticky: assert property (@(posedge clock) disable iff (rst)
        evt[0] |=> status[0])
        else $error("event did not set status");
    a_irq_level: assert property (@(posedge clock) disable iff (rst)
        (|(status & mask)) |=> irq)
        else $error("irq not raised for unmasked status");
    a_unfilt_pass: assert property (@(posedge clock) disable iff (rst)
        !ctl[0][ctl_filter_enable_bit_bit] |=> filt[0] == $past(raw[0]))
        else $error("unfiltered path delayed");
    a_filt_hold: assert property (@(posedge clock) disable iff (rst)
        (ctl[0][ctl_filter_enable_bit_bit] && $stable(ctl[0]) && !line[0].tick) |=> $stable(filt[0]))
        else $error("filter changed off a sample tick");
    a_rise_pulse: assert property (@(posedge clock) disable iff (rst)
        (ctl[0][1:0] == trig_rise && $rose(filt[0])) |=> evt[0] ##1 !evt[0])
        else $error("rising edge not one pulse");
    a_cpu_route: assert property (@(posedge clock) disable iff (rst)
        (evt[0] && route[1:0] == 2'h0) |=> evt_cpu[0])
        else $error("event not routed to cpu");
    a_select_gate: assert property (@(posedge clock) disable iff (rst)
        !used[0] |-> raw[0])
        else $error("unselected pin drives line");
    a_div8_rate: assert property (@(posedge clock) disable iff (rst)
        (ctl[0][5:4] == 2'h1 && line[0].tick) |=> !line[0].tick [*7])
        else $error("divide by 8 tick too frequent");
    a_low_level: assert property (@(posedge clock) disable iff (rst)
        (ctl[0][1:0] == trig_low && !filt[0]) |=> evt[0])
        else $error("low level not detected");
    a_wake_level: assert property (@(posedge clock) disable iff (rst)
        (|(wake_line & ~filt)) |=> wake_req)
        else $error("wake request missing");
    a_dtc_route: assert property (@(posedge clock) disable iff (rst)
        (evt[0] && route[1:0] == 2'h1) |=> (evt_dtc[0] && !evt_cpu[0]))
        else $error("event not routed to transfer controller");
    a_periph_path: assert property (@(posedge clock) disable iff (rst)
        (psync[0] && pin_function_reg[0][pfs_psel_bit]) |=> periph_in[0])
        else $error("peripheral path blocked");
    a_status_clear: assert property (@(posedge clock) disable iff (rst)
        (st_clr[0] && !evt[0]) |=> !status[0])
        else $error("status not cleared");

endmodule // irq_pin_front

// File: core/irq_pin_pkg.sv
/*
 * constants and types for the external interrupt pin front end.
 * assumes a single peripheral clock and a plain register port.
 */
// Overview of operation
// - a pin feeds an interrupt line only while its irq_input_select bit is 1.
// - irq_input_select works independently of the peripheral function select of the pin.
// - the normal pin and deep standby wake pin of one number share one internal line.
// - deep standby wake pins can raise a wake request, ordinary pins only when sharing a line with one.
// - each line detects low level, falling, rising or both edges as selected.
// - the filter samples at the clock or the clock divided by 8, 32 or 64, per line.
// - with filtering on, pulses shorter than three samples are rejected.
// - each line has its own filter_enable_bit.
// - filtering delays the event by the filter time, without it there is no such delay.
// - events go out to the interrupt_event_router for cpu, transfer or dma use.
package irq_pin_pkg;

    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam logic [7:0] pin_function_reg_base = 8'h00;
    localparam logic [7:0] irq_line_control_reg_base = 8'h40;
    localparam logic [7:0] irq_status_addr = 8'h80;
    localparam logic [7:0] irq_mask_addr = 8'h84;
    localparam logic [7:0] irq_route_addr = 8'h88;
    localparam logic [7:0] irq_wake_addr = 8'h8c;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int pfs_irq_input_select_bit = 0;
    localparam int pfs_psel_bit = 1;
    localparam int pfs_ds_bit = 2;
    localparam int ctl_mode_lsb = 0;
    localparam int ctl_fclk_lsb = 4;
    localparam int ctl_filter_enable_bit_bit = 7;

    // --------------------------------------------------------------
    // reset values and counts
    // --------------------------------------------------------------
    localparam logic [7:0] ctl_reset = 8'h00;
    localparam logic [2:0] pfs_reset = 3'h0;
    localparam logic [5:0] div8_last = 6'h07;
    localparam logic [5:0] div32_last = 6'h1f;
    localparam logic [5:0] div64_last = 6'h3f;
    localparam int filter_samples = 3;

    typedef enum logic [1:0] {
        trig_low = 2'h0,
        trig_fall = 2'h1,
        trig_rise = 2'h2,
        trig_both = 2'h3
    } trig_t;

endpackage

// File: verif/pin_sources.sv
/*
 * external signal sources on the interrupt pins.
 * assumes the bench calls its tasks right after a clock edge.
 */
`timescale 1ns/1ps
module pin_sources
(
    // pin levels
    output logic [7:0] pins
);
    initial pins = 8'hff;
    // edges land mid-cycle, the pins are not tied to the clock
    task automatic drive(input int p, input logic v);
        #3 pins[p] = v;
    endtask
    task automatic pulse(input int p, input int ns);
        #3 pins[p] = ~pins[p];
        #(ns) pins[p] = ~pins[p];
    endtask
endmodule // pin_sources

// File: verif/tb_top.sv
/*
 * self-checking bench for the interrupt pin front end.
 * assumes one clock and pin_sources on the pins.
 */
`timescale 1ns/1ps
module tb_top
    import irq_pin_pkg::*;
;
    logic clock;
    logic rst;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    wire logic [7:0] pin_in;
    logic [7:0] periph_in;
    logic [3:0] evt_cpu;
    logic [3:0] evt_dtc;
    logic [3:0] evt_dma;
    logic wake_req;
    logic irq;
    int fails = 0;
    int n_tests = 0;
    int n_ev[3] = '{0, 0, 0};
    int k;
    int div;

    pin_sources src (.pins(pin_in));
    irq_pin_front DUT (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pin_in(pin_in), .periph_in(periph_in), .evt_cpu(evt_cpu),
        .evt_dtc(evt_dtc), .evt_dma(evt_dma), .wake_req(wake_req), .irq(irq));

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // events of line 0 per destination
    always @(posedge clock)
    begin
        n_ev[0] <= n_ev[0] + evt_cpu[0];
        n_ev[1] <= n_ev[1] + evt_dtc[0];
        n_ev[2] <= n_ev[2] + evt_dma[0];
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // read data stand only in the cycle after the strobe
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        idle(20000);
        fails++;
        results;
    end

    initial
    begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        idle(10);
        rst <= 1'b0;
        chk_reg(irq_line_control_reg_base, {24'h0, ctl_reset});
        chk_reg(8'hfc, 32'h0);
        check(irq, 1'b0);
        wreg(irq_route_addr, 32'hfc);
        wreg(irq_line_control_reg_base, trig_fall);
        src.pulse(0, 80);
        idle(20);
        chk_reg(irq_status_addr, 32'h0);
        wreg(pin_function_reg_base, 32'h3);
        for (int m = 0; m < 4; m++)
        begin
            wreg(irq_line_control_reg_base, m);
            wreg(irq_status_addr, 32'h1);
            src.drive(0, 1'b0);
            idle(20);
            chk_reg(irq_status_addr, m != 2);
            check(periph_in[0], 1'b0);
            k = n_ev[0];
            src.drive(0, 1'b1);
            idle(20);
            check(periph_in[0], 1'b1);
            if (m > 0) check(n_ev[0] - k, m >= 2);
        end
        for (int f = 0; f < 4; f++)
        begin
            div = (f == 0) ? 1 : (f == 1) ? 8 : (f == 2) ? 32 : 64;
            wreg(irq_line_control_reg_base, trig_fall | f << ctl_fclk_lsb | 1 << ctl_filter_enable_bit_bit);
            wreg(irq_status_addr, 32'h1);
            src.pulse(0, (2 * div - 1) * 8);
            idle(8 * div + 20);
            chk_reg(irq_status_addr, 32'h0);
            src.drive(0, 1'b0);
            idle(12);
            if (f > 0) chk_reg(irq_status_addr, 32'h0);
            idle(5 * div);
            src.drive(0, 1'b1);
            idle(8 * div + 20);
            chk_reg(irq_status_addr, 32'h1);
        end
        // unfiltered: short pulses pass with no delay
        wreg(irq_line_control_reg_base, trig_fall);
        wreg(irq_status_addr, 32'h1);
        src.drive(0, 1'b0);
        idle(12);
        chk_reg(irq_status_addr, 32'h1);
        src.drive(0, 1'b1);
        idle(10);
        wreg(irq_status_addr, 32'h1);
        src.pulse(0, 16);
        idle(20);
        chk_reg(irq_status_addr, 32'h1);
        for (int r = 0; r < 3; r++)
        begin
            wreg(irq_route_addr, 32'hfc | r);
            k = n_ev[r];
            src.pulse(0, 80);
            idle(20);
            check(n_ev[r] - k, 32'h1);
        end
        check(n_ev[0] + n_ev[1] + n_ev[2], 32'h23);
        wreg(irq_mask_addr, 32'h0);
        idle(3);
        check(irq, 1'b0);
        wreg(irq_mask_addr, 32'h1);
        idle(3);
        check(irq, 1'b1);
        wreg(irq_status_addr, 32'h1);
        idle(3);
        check(irq, 1'b0);
        // pin 1 as wake pin of line 1, then pin 2 as the plain pin of that line
        wreg(pin_function_reg_base + 8'h04, 32'h105);
        wreg(irq_line_control_reg_base + 8'h04, trig_fall);
        chk_reg(irq_wake_addr, 32'h2);
        src.drive(1, 1'b0);
        idle(20);
        check(wake_req, 1'b1);
        src.drive(1, 1'b1);
        wreg(pin_function_reg_base + 8'h04, 32'h0);
        wreg(pin_function_reg_base + 8'h08, 32'h101);
        idle(20);
        wreg(irq_status_addr, 32'hf);
        src.drive(2, 1'b0);
        idle(20);
        check(wake_req, 1'b0);
        chk_reg(irq_status_addr, 32'h2);
        results;
    end
endmodule // tb_top
